// ---- sie_regs.svh ----
/*
  Constants of the port event logic: status bit positions, sizes, timing.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef SIE_REGS_SVH
`define SIE_REGS_SVH
// ==========================================
// status word bit positions
`define SIE_ST_IRQ   0
`define SIE_ST_TX_UNDERRUN_FLAG  4
`define SIE_ST_TX_COUNT_INTERRUPT 5
`define SIE_ST_RX_COUNT_INTERRUPT 6
`define SIE_ST_RX_OVERFLOW_OVERWRITE_OR_FLAG  7
`define SIE_ST_SELECT_ERROR_FLAG 12
// ==========================================
// sizes and reset values
`define SIE_DEPTH     4'h8
`define SIE_PTR_W     3
`define SIE_LVL_W     4
`define SIE_BIT_LAST  3'h7
`define SIE_BYTE_RST  8'h00
`define SIE_CS_STAGES 5
`endif

// ---- sie_pkg.sv ----
/*
  Types of the port event logic: control bundle, flag bundle, byte state.
  Assumes sie_regs.svh is reachable by bare name.
*/
`default_nettype none
package sie_pkg;
  typedef struct packed {
    logic       portEnable;
    logic       masterMode;
    logic       wireOrSelect;
    logic       zeroFillEnable;
    logic       rxOverflowOverwrite;
    logic       transferInitiateSelect;
    logic       rxFlushEnable;
    logic       txFlushEnable;
    logic       selectErrorResetEnable;
    logic       rxIrqDisable;
    logic       dmaEnable;
    logic       dmaTxEnable;
    logic       dmaRxEnable;
    logic [2:0] irqMode;
  } sie_ctrl_s;

  typedef struct packed {
    logic selectErrorFlag;
    logic rxOverflowFlag;
    logic rxCountInterrupt;
    logic txCountInterrupt;
    logic txUnderrunFlag;
  } sie_flags_s;

  typedef enum logic [1:0] {
    BYTE_IDLE = 2'b01,
    BYTE_BUSY = 2'b10
  } sie_byte_e;
endpackage
`default_nettype wire

// ---- sie_core.sv ----
/*
  Byte-wide serial port event logic: transmit and receive FIFOs, count
  interrupts, underrun, overflow and select-error flags, wire-OR pad
  drive and DMA request gating.
  Assumes the link clock runs only inside frames and that control bits
  are quasi-static while a frame is in progress.
*/
//
// Contract
// - empty transmit start resends last byte, or zeros when zero fill set.
// - full receive FIFO: overwrite when overwrite bit set, else drop byte.
// - master duplex transmit flag appears about three to four serial clocks in.
// - receive level reflects the first byte about twelve serial clocks after select.
// - one interrupt line from five sources, mirrored in status bits.
// - transfer-initiate bit chooses transmit or receive count interrupt.
// - source flags are sticky; line drops only after all are cleared.
// - mode N raises transmit interrupt every N+1 bytes loaded to shifter.
// - count transmitted bytes; control write resets the counter to zero.
// - transmit interrupt in bit five, read-cleared, suppressed by transmit flush.
// - receive interrupt checked on byte entry, when level reaches mode plus one.
// - receive interrupt in bit six, read-cleared, suppressed by its disable bit.
// - transfer start with empty transmit FIFO sets underrun unless flushing.
// - byte into full receive FIFO sets overflow unless receive flushing.
// - flags clear on status read or port disable; flush clears count flags.
// - wire-OR bit makes both data outputs open-drain via pad enables.
// - select rising before eight clocks of a byte sets select error.
// - DMA suppresses count interrupts, keeps underrun and overflow.
// - DMA requests only while DMA enabled; queued bytes still go out.
// - receive-only DMA runs transmit FIFO empty and reports underrun.
// - receive flush stores nothing; transmit flush avoids underrun reports.
// - port works only while the port enable bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "sie_regs.svh"
module sie_core (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              serialClock,
  input  wire logic              chipSelectN,
  input  wire logic              mosiIn,
  input  wire logic              misoIn,
  output var  logic              mosiOut,
  output var  logic              mosiOeN,
  output var  logic              misoOut,
  output var  logic              misoOeN,
  input  wire sie_pkg::sie_ctrl_s  ctrl,
  input  wire logic              ctrlWr,
  input  wire logic              statRd,
  input  wire sie_pkg::sie_flags_s flagW1c,
  input  wire logic              txWrValid,
  input  wire logic [7:0]        txWrData,
  output var  logic              txWrReady,
  output var  logic              rxRdValid,
  output var  logic [7:0]        rxRdData,
  input  wire logic              rxRdReady,
  output var  logic [15:0]       statusWord,
  output var  logic [3:0]        txLevel,
  output var  logic [3:0]        rxLevel,
  output var  logic              irqOut,
  output var  logic              dmaTxReq,
  output var  logic              dmaRxReq
);
  import sie_pkg::*;

  // ==========================================
  // link domain: bit shifter on the serial clock
  logic [2:0] bitCnt_reg;
  logic [7:0] shiftOut_reg;
  logic [7:0] shiftIn_reg;
  logic [7:0] rxByte_reg;
  logic       startTgl_reg;
  logic       doneTgl_reg;
  logic [7:0] nextTx_reg;
  logic       linkRstN;
  logic       dataIn;
  logic       txBit;

  // select high clears a half byte only when select-error reset is set
  assign linkRstN = nrst & ctrl.portEnable & ~(chipSelectN & ctrl.selectErrorResetEnable);
  assign dataIn   = ctrl.masterMode ? misoIn : mosiIn;
  assign txBit    = (bitCnt_reg == 3'h0) ? nextTx_reg[7] : shiftOut_reg[7];

  always_ff @(posedge serialClock or negedge linkRstN) begin
    if (!linkRstN) begin
      bitCnt_reg   <= 3'h0;
      shiftOut_reg <= `SIE_BYTE_RST;
      shiftIn_reg  <= `SIE_BYTE_RST;
    end else begin
      bitCnt_reg  <= bitCnt_reg + 3'h1;
      shiftIn_reg <= {shiftIn_reg[6:0], dataIn};
      if (bitCnt_reg == 3'h0) begin
        shiftOut_reg <= {nextTx_reg[6:0], 1'b0};
      end else begin
        shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
      end
    end
  end

  // event toggles keep their own reset so a select reset makes no false event
  always_ff @(posedge serialClock or negedge nrst) begin
    if (!nrst) begin
      startTgl_reg <= 1'b0;
      doneTgl_reg  <= 1'b0;
      rxByte_reg   <= `SIE_BYTE_RST;
    end else begin
      if (linkRstN && bitCnt_reg == 3'h0) begin
        startTgl_reg <= ~startTgl_reg;
      end
      if (linkRstN && bitCnt_reg == `SIE_BIT_LAST) begin
        doneTgl_reg <= ~doneTgl_reg;
        rxByte_reg  <= {shiftIn_reg[6:0], dataIn};
      end
    end
  end

  // ==========================================
  // crossings into the system clock
  logic [2:0]               startSync_reg;
  logic [2:0]               doneSync_reg;
  logic [`SIE_CS_STAGES-1:0] csSync_reg;
  logic                     startEv;
  logic                     doneEv;
  logic                     csRise;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      startSync_reg <= 3'h0;
      doneSync_reg  <= 3'h0;
      csSync_reg    <= '1;
    end else begin
      startSync_reg <= {startSync_reg[1:0], startTgl_reg};
      doneSync_reg  <= {doneSync_reg[1:0], doneTgl_reg};
      csSync_reg    <= {csSync_reg[`SIE_CS_STAGES-2:0], chipSelectN};
    end
  end

  // start seen about three to four link periods into the byte
  assign startEv = (startSync_reg[2] ^ startSync_reg[1]) & ctrl.portEnable;
  // received byte lands in the FIFO about twelve link periods after select
  assign doneEv  = (doneSync_reg[2] ^ doneSync_reg[1]) & ctrl.portEnable;
  // delayed past the done crossing so a complete byte is never flagged
  assign csRise  = ~csSync_reg[`SIE_CS_STAGES-1]
                 & csSync_reg[`SIE_CS_STAGES-2];

  // ==========================================
  // transmit FIFO
  logic [7:0]            txMem_reg [`SIE_DEPTH];
  logic [`SIE_PTR_W-1:0] txWrPtr_reg;
  logic [`SIE_PTR_W-1:0] txRdPtr_reg;
  logic [`SIE_LVL_W-1:0] txCnt_reg;
  logic [7:0]            lastSent_reg;
  logic                  txPush;
  logic                  txPop;
  logic                  txEmpty;

  assign txEmpty   = (txCnt_reg == 4'h0);
  assign txWrReady = (txCnt_reg != `SIE_DEPTH);
  assign txPush    = txWrValid & txWrReady;
  assign txPop     = startEv & ~txEmpty;
  assign txLevel   = txCnt_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txWrPtr_reg  <= '0;
      txRdPtr_reg  <= '0;
      txCnt_reg    <= 4'h0;
      lastSent_reg <= `SIE_BYTE_RST;
    end else begin
      if (txPush) begin
        txWrPtr_reg <= txWrPtr_reg + 3'h1;
      end
      if (txPop) begin
        txRdPtr_reg  <= txRdPtr_reg + 3'h1;
        lastSent_reg <= txMem_reg[txRdPtr_reg];
      end
      txCnt_reg <= txCnt_reg + {3'h0, txPush} - {3'h0, txPop};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (txPush) begin
      txMem_reg[txWrPtr_reg] <= txWrData;
    end
  end

  // byte offered to the shifter: head, else zeros or the last byte again
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nextTx_reg <= `SIE_BYTE_RST;
    end else if (!txEmpty) begin
      nextTx_reg <= txMem_reg[txRdPtr_reg];
    end else if (ctrl.zeroFillEnable) begin
      nextTx_reg <= `SIE_BYTE_RST;
    end else begin
      nextTx_reg <= lastSent_reg;
    end
  end

  // ==========================================
  // receive FIFO
  logic [7:0]            rxMem_reg [`SIE_DEPTH];
  logic [`SIE_PTR_W-1:0] rxWrPtr_reg;
  logic [`SIE_PTR_W-1:0] rxRdPtr_reg;
  logic [`SIE_LVL_W-1:0] rxCnt_reg;
  logic                  rxFull;
  logic                  rxPush;
  logic                  rxPop;
  logic                  rxDropOld;
  logic [`SIE_LVL_W-1:0] rxLvlAfter;

  assign rxFull    = (rxCnt_reg == `SIE_DEPTH);
  assign rxRdValid = (rxCnt_reg != 4'h0);
  assign rxPop     = rxRdValid & rxRdReady;
  // flush stores nothing; a full FIFO overwrites or drops
  assign rxPush    = doneEv & ~ctrl.rxFlushEnable & (~rxFull | ctrl.rxOverflowOverwrite | rxPop);
  assign rxDropOld = rxPush & rxFull & ~rxPop;
  assign rxLvlAfter = rxFull ? `SIE_DEPTH : rxCnt_reg + 4'h1;
  assign rxLevel   = rxCnt_reg;
  assign rxRdData  = rxMem_reg[rxRdPtr_reg];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxWrPtr_reg <= '0;
      rxRdPtr_reg <= '0;
      rxCnt_reg   <= 4'h0;
    end else begin
      if (rxPush) begin
        rxWrPtr_reg <= rxWrPtr_reg + 3'h1;
      end
      if (rxPop || rxDropOld) begin
        rxRdPtr_reg <= rxRdPtr_reg + 3'h1;
      end
      rxCnt_reg <= rxCnt_reg + {3'h0, rxPush & ~rxDropOld} - {3'h0, rxPop};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rxPush) begin
      rxMem_reg[rxWrPtr_reg] <= rxByte_reg;
    end
  end

  // ==========================================
  // byte progress for the select error check
  sie_byte_e byteState_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      byteState_reg <= BYTE_IDLE;
    end else if (!ctrl.portEnable) begin
      byteState_reg <= BYTE_IDLE;
    end else begin
      case (byteState_reg)
        BYTE_IDLE: begin
          if (startEv) begin
            byteState_reg <= BYTE_BUSY;
          end
        end
        BYTE_BUSY: begin
          // a done and the next start may cross in one cycle: stay busy then
          if ((doneEv && !startEv) || (csRise && ctrl.selectErrorResetEnable)) begin
            byteState_reg <= BYTE_IDLE;
          end
        end
        default: begin
          byteState_reg <= BYTE_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // transmitted byte counter and flags
  logic [2:0] txSent_reg;
  logic       dmaActive;
  logic       txHit;
  sie_flags_s flags_reg;
  sie_flags_s flagSet;
  sie_flags_s flagClr;

  assign dmaActive = ctrl.dmaEnable & (ctrl.dmaTxEnable | ctrl.dmaRxEnable);
  assign txHit     = txPop & (txSent_reg == ctrl.irqMode);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txSent_reg <= 3'h0;
    end else if (ctrlWr || !ctrl.portEnable) begin
      txSent_reg <= 3'h0;
    end else if (txPop) begin
      txSent_reg <= txHit ? 3'h0 : txSent_reg + 3'h1;
    end
  end

  always_comb begin
    flagSet.txUnderrunFlag   = startEv & txEmpty & ~ctrl.txFlushEnable;
    flagSet.txCountInterrupt = txHit & ctrl.transferInitiateSelect & ~ctrl.txFlushEnable
                             & ~dmaActive;
    flagSet.rxCountInterrupt = rxPush & (rxLvlAfter > {1'b0, ctrl.irqMode}) & ~ctrl.transferInitiateSelect
                             & ~ctrl.rxIrqDisable & ~dmaActive;
    flagSet.rxOverflowFlag   = doneEv & rxFull & ~rxPop & ~ctrl.rxFlushEnable;
    flagSet.selectErrorFlag  = csRise & (byteState_reg == BYTE_BUSY) & ctrl.portEnable;
    flagClr = flagW1c;
    if (statRd || !ctrl.portEnable) begin
      flagClr = '1;
    end
    flagClr.txCountInterrupt = flagClr.txCountInterrupt | ctrl.txFlushEnable;
    flagClr.rxCountInterrupt = flagClr.rxCountInterrupt | ctrl.rxFlushEnable;
  end

  // a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flagSet | (flags_reg & ~flagClr);
    end
  end

  // ==========================================
  // interrupt line, status word, DMA requests, pads
  assign irqOut = |flags_reg;

  always_comb begin
    statusWord                = 16'h0000;
    statusWord[`SIE_ST_IRQ]   = irqOut;
    statusWord[`SIE_ST_TX_UNDERRUN_FLAG]  = flags_reg.txUnderrunFlag;
    statusWord[`SIE_ST_TX_COUNT_INTERRUPT] = flags_reg.txCountInterrupt;
    statusWord[`SIE_ST_RX_COUNT_INTERRUPT] = flags_reg.rxCountInterrupt;
    statusWord[`SIE_ST_RX_OVERFLOW_OVERWRITE_OR_FLAG]  = flags_reg.rxOverflowFlag;
    statusWord[`SIE_ST_SELECT_ERROR_FLAG] = flags_reg.selectErrorFlag;
  end

  assign dmaTxReq = ctrl.dmaEnable & ctrl.dmaTxEnable & txWrReady;
  assign dmaRxReq = ctrl.dmaEnable & ctrl.dmaRxEnable & rxRdValid;

  // with wire-OR set, open-drain: pull low only, release for a one; otherwise driven both ways
  always_comb begin
    mosiOut = ctrl.wireOrSelect ? 1'b0 : txBit;
    misoOut = mosiOut;
    mosiOeN = ~(ctrl.portEnable & ctrl.masterMode & (~ctrl.wireOrSelect | ~txBit));
    misoOeN = ~(ctrl.portEnable & ~ctrl.masterMode & ~csSync_reg[1]
              & (~ctrl.wireOrSelect | ~txBit));
  end

  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_zero_fill: assert property (txEmpty && ctrl.zeroFillEnable |=> nextTx_reg == 8'h00)
    else $error("zero fill byte not offered");
  a_rx_drop: assert property (doneEv && rxFull && !rxPop && !ctrl.rxOverflowOverwrite
    |=> rxLevel == 4'h8 && $stable(rxWrPtr_reg))
    else $error("byte into full FIFO not dropped");
  a_tx_count: assert property (txHit && ctrl.transferInitiateSelect && !ctrl.txFlushEnable
    && !dmaActive |=> flags_reg.txCountInterrupt && txSent_reg == 3'h0)
    else $error("transmit count interrupt missing");
  a_ctl_reset: assert property (ctrlWr |=> txSent_reg == 3'h0)
    else $error("control write did not reset counter");
  a_tx_flush: assert property (ctrl.txFlushEnable [*2] |-> !flags_reg.txCountInterrupt)
    else $error("transmit interrupt while flushing");
  a_rx_new_byte: assert property ($rose(flags_reg.rxCountInterrupt) |-> $past(rxPush))
    else $error("receive interrupt without new byte");
  a_underrun: assert property (startEv && txEmpty && !ctrl.txFlushEnable
    |=> flags_reg.txUnderrunFlag && irqOut)
    else $error("underrun not flagged");
  a_overflow: assert property (flagSet.rxOverflowFlag |=> flags_reg.rxOverflowFlag && irqOut)
    else $error("overflow not flagged");
  a_disable_clr: assert property (!ctrl.portEnable |=> flags_reg == '0 && !irqOut)
    else $error("flags survive port disable");
  a_sel_error: assert property (csRise && byteState_reg == BYTE_BUSY && ctrl.portEnable
    |=> flags_reg.selectErrorFlag)
    else $error("select error not flagged");
  a_dma_gate: assert property (!ctrl.dmaEnable |-> !dmaTxReq && !dmaRxReq)
    else $error("DMA request while disabled");
  a_wire_or: assert property (ctrl.wireOrSelect && (!mosiOeN || !misoOeN) |-> !misoOut && !txBit)
    else $error("wire-OR drives a one");
  a_count_sel: assert property ($rose(flags_reg.txCountInterrupt) |-> $past(ctrl.transferInitiateSelect))
    else $error("transmit interrupt with receive selected");

  c_underrun: cover property (flags_reg.txUnderrunFlag ##1 statRd);
  c_overwrite: cover property (rxDropOld);
  c_sel_error: cover property (flagSet.selectErrorFlag);
  c_rx_irq: cover property (flagSet.rxCountInterrupt ##[1:20] rxPop);
endmodule
`default_nettype wire

// ---- sie_far_master.sv ----
/*
  Far-side master model: drives the serial clock, select and data in, and
  captures the port's data out byte by byte, MSB first.
  Assumes the port shifts on the serial clock rise; data out is taken just before each rise.
*/
`timescale 1ns/1ps
`default_nettype none
module sie_far_master (
  output var  logic serialClock,
  output var  logic chipSelectN,
  output var  logic mosi,
  input  wire logic miso
);
  logic [7:0] outQ[$];
  logic [7:0] inQ[$];
  initial begin
    serialClock = 1'b0;
    chipSelectN = 1'b1;
    mosi        = 1'b1;
  end
  // ==========================================
  // one frame of nBits bits; clock stands still outside it
  task automatic frame(input int nBits);
    logic [7:0] o;
    logic [7:0] i;
    int         k;
    o = 8'h00;
    i = 8'h00;
    #7 chipSelectN = 1'b0;
    #100;
    for (k = 0; k < nBits; k++) begin
      if (k % 8 == 0) begin
        o = outQ.pop_front();
      end
      mosi = o[7 - k % 8];
      // the port changes data out on the rise, so take it just before
      #15 i[7 - k % 8] = miso;
      serialClock = 1'b1;
      #15 serialClock = 1'b0;
      if (k % 8 == 7) begin
        inQ.push_back(i);
      end
    end
    #15 chipSelectN = 1'b1;
    // released line shows the inverse of its last value
    mosi = ~mosi;
  endtask
endmodule
`default_nettype wire

// ---- tb_spi_irq_error_dma_logic.sv ----
/*
  Self-checking bench of the port event logic with a queue model.
  Assumes the design runs in slave mode against sie_far_master.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_spi_irq_error_dma_logic;
  import sie_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, ctrlWr = 1'b0, statRd = 1'b0;
  logic txWrValid = 1'b0, rxRdReady = 1'b0;
  logic [7:0] txWrData = 8'h00, lastTx = 8'h00;
  logic [15:0] lfsr = 16'h6CB3, expW;
  sie_ctrl_s ctrl = '0, c;
  sie_flags_s flagW1c = '0;
  wire logic serialClock, chipSelectN, mosiWire, mosiOut, mosiOeN, misoOut, misoOeN;
  wire logic txWrReady, rxRdValid, irqOut, dmaTxReq, dmaRxReq;
  wire logic [7:0] rxRdData;
  wire logic [15:0] statusWord;
  wire logic [3:0] txLevel, rxLevel;
  // data out has a pull-up
  wire logic misoWire = (misoOeN === 1'b0) ? misoOut : 1'b1;
  logic [7:0] txQ[$], rxQ[$], expQ[$];
  logic mUr = 0, mTx = 0, mRx = 0, mOf = 0, mCs = 0;
  int txCnt = 0, n_mismatch = 0, num_checks = 0, cyc = 0;
  sie_far_master pm (.serialClock(serialClock), .chipSelectN(chipSelectN), .mosi(mosiWire), .miso(misoWire));
  sie_core dut_u (.ref_clk(ref_clk), .nrst(nrst), .serialClock(serialClock), .chipSelectN(chipSelectN),
    .mosiIn(mosiWire), .misoIn(misoWire), .mosiOut(mosiOut), .mosiOeN(mosiOeN), .misoOut(misoOut),
    .misoOeN(misoOeN), .ctrl(ctrl), .ctrlWr(ctrlWr), .statRd(statRd), .flagW1c(flagW1c),
    .txWrValid(txWrValid), .txWrData(txWrData), .txWrReady(txWrReady), .rxRdValid(rxRdValid),
    .rxRdData(rxRdData), .rxRdReady(rxRdReady), .statusWord(statusWord), .txLevel(txLevel),
    .rxLevel(rxLevel), .irqOut(irqOut), .dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq));
  always #20 ref_clk = ~ref_clk;
  // ==========================================
  // checking and reporting
  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc >= 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ==========================================
  // drivers and model
  function automatic logic [15:0] nextLfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chkStat();
    expW = {3'h0, mCs, 4'h0, mOf, mRx, mTx, mUr, 3'h0, mCs | mOf | mRx | mTx | mUr};
    chkWord(statusWord, expW);
    chkWord({15'h0, irqOut}, {15'h0, expW[0]});
    chkWord({12'h0, txLevel}, 16'(txQ.size()));
    chkWord({12'h0, rxLevel}, 16'(rxQ.size()));
  endtask
  task automatic setCtrl(input sie_ctrl_s v);
    ctrl = v;
    ctrlWr = 1'b1;
    txCnt = 0;
    if (v.txFlushEnable) mTx = 0;
    if (v.rxFlushEnable) mRx = 0;
    if (!v.portEnable) {mUr, mTx, mRx, mOf, mCs} = 5'h00;
    step();
    ctrlWr = 1'b0;
    step();
  endtask
  task automatic clr();
    statRd = 1'b1;
    {mUr, mTx, mRx, mOf, mCs} = 5'h00;
    step();
    statRd = 1'b0;
    step();
    chkStat();
  endtask
  task automatic pushN(input int n);
    for (int k = 0; k < n; k++) begin
      lfsr = nextLfsr(lfsr);
      txWrData = lfsr[7:0];
      txWrValid = 1'b1;
      if (txQ.size() < 8) txQ.push_back(lfsr[7:0]);
      step();
    end
    txWrValid = 1'b0;
  endtask
  task automatic xfer(input int n);
    logic [7:0] b;
    logic [7:0] e;
    for (int k = 0; k < n; k++) begin
      lfsr = nextLfsr(lfsr);
      b = lfsr[7:0];
      pm.outQ.push_back(b);
      if (txQ.size() > 0) begin
        e = txQ.pop_front();
        lastTx = e;
        txCnt++;
        if (txCnt == int'(ctrl.irqMode) + 1) begin
          txCnt = 0;
          if (ctrl.transferInitiateSelect && !ctrl.dmaEnable && !ctrl.txFlushEnable) mTx = 1;
        end
      end else begin
        e = ctrl.zeroFillEnable ? 8'h00 : lastTx;
        if (!ctrl.txFlushEnable) mUr = 1;
      end
      expQ.push_back(e);
      if (!ctrl.rxFlushEnable) begin
        if (rxQ.size() == 8) begin
          mOf = 1;
          if (ctrl.rxOverflowOverwrite) void'(rxQ.pop_front());
        end
        if (rxQ.size() < 8) begin
          rxQ.push_back(b);
          if (rxQ.size() > int'(ctrl.irqMode) && !ctrl.transferInitiateSelect && !ctrl.rxIrqDisable &&
              !ctrl.dmaEnable) mRx = 1;
        end
      end
    end
    pm.frame(8 * n);
    repeat (12) step();
    while (expQ.size() > 0) chkByte(pm.inQ.pop_front(), expQ.pop_front());
    chkStat();
  endtask
  task automatic drain(input bit cmp);
    while (rxQ.size() > 0) begin
      if (cmp) chkByte(rxRdData, rxQ[0]);
      void'(rxQ.pop_front());
      rxRdReady = 1'b1;
      step();
    end
    rxRdReady = 1'b0;
    step();
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 nrst = 1'b1;
    step();
    chkStat();
    c = '0;
    c.portEnable = 1;
    c.selectErrorResetEnable = 1;
    c.rxFlushEnable = 1;
    c.transferInitiateSelect = 1;
    for (int m = 0; m < 8; m++) begin
      c.irqMode = 3'(m);
      setCtrl(c);
      pushN(m + 1);
      xfer(m + 1);
      clr();
    end
    c.irqMode = 3'h2;
    setCtrl(c);
    pushN(2);
    xfer(2);
    setCtrl(c);
    pushN(2);
    xfer(2);
    pushN(1);
    xfer(1);
    clr();
    c.irqMode = 3'h0;
    for (int z = 0; z < 2; z++) begin
      c.zeroFillEnable = z[0];
      setCtrl(c);
      pushN(1);
      xfer(2);
      clr();
    end
    c.wireOrSelect = 1;
    setCtrl(c);
    pushN(3);
    xfer(3);
    clr();
    c.wireOrSelect = 0;
    c.irqMode = 3'h7;
    setCtrl(c);
    pushN(9);
    chkWord({15'h0, txWrReady}, 16'h0000);
    xfer(9);
    clr();
    c.txFlushEnable = 1;
    setCtrl(c);
    xfer(1);
    c.transferInitiateSelect = 0;
    c.rxFlushEnable = 0;
    c.irqMode = 3'h1;
    setCtrl(c);
    xfer(1);
    xfer(1);
    clr();
    repeat (4) step();
    chkStat();
    drain(1);
    c.rxIrqDisable = 1;
    setCtrl(c);
    xfer(9);
    clr();
    drain(1);
    c.rxOverflowOverwrite = 1;
    setCtrl(c);
    xfer(9);
    clr();
    drain(0);
    c.rxOverflowOverwrite = 0;
    c.rxFlushEnable = 1;
    setCtrl(c);
    xfer(9);
    c = '0;
    c.portEnable = 1;
    c.selectErrorResetEnable = 1;
    c.transferInitiateSelect = 1;
    c.dmaEnable = 1;
    c.dmaTxEnable = 1;
    c.dmaRxEnable = 1;
    setCtrl(c);
    chkWord({14'h0, dmaTxReq, dmaRxReq}, 16'h0002);
    xfer(1);
    chkWord({14'h0, dmaTxReq, dmaRxReq}, 16'h0003);
    c.dmaEnable = 0;
    setCtrl(c);
    chkWord({14'h0, dmaTxReq, dmaRxReq}, 16'h0000);
    clr();
    drain(1);
    c.txFlushEnable = 1;
    c.rxFlushEnable = 1;
    setCtrl(c);
    pm.outQ.push_back(8'hA5);
    pm.frame(3);
    repeat (12) step();
    mCs = 1;
    chkStat();
    flagW1c.selectErrorFlag = 1'b1;
    step();
    flagW1c = '0;
    mCs = 0;
    step();
    chkStat();
    c.txFlushEnable = 0;
    setCtrl(c);
    xfer(1);
    c.portEnable = 0;
    setCtrl(c);
    chkWord(statusWord, 16'h0000);
    chkWord({14'h0, mosiOeN, misoOeN}, 16'h0003);
    final_report();
  end
endmodule
`default_nettype wire
